// >>> rtl/fcp_flow_ctrl.sv
// fcp_flow_ctrl: per-port pause flow control for a multi-port gigabit mac.
// assumes decoded 8b10b bytes from each port's pcs with a sampled link
// clock, watermark levels from the rx fifo and a busy level from the mac.
// Behaviour
// - pause frame: opcode, type and multicast match
// - keep sending pauses while fifo stays high
// - early drain sends zero-time pause
// - sent pause length from pause length register
// - refresh pause when remaining reaches threshold
// - act on pauses only with rx enable
// - accept own station address as well
// - hold transmitter for received quanta
// - current frame finishes before hold starts
// - honour pauses regardless of filter settings
// - trigger port is asynchronous address plus strobe
// - trigger acts only on enabled ports
// - trigger zero sends xon everywhere
// - trigger one to ten sends xoff
// - trigger fifteen sends xoff everywhere; others reserved
// - pause length resets to 0x05e
// - data path is decoded 8-bit bytes with a k flag
// - autoneg off by default, forced gigabit
// - forced mode passes packets only when synced
// - k28.1 is an unknown control word
// - xoff at high mark, xon below low
// - independent rx and tx enable bits
// - pause frames padded to minimum size
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module fcp_flow_ctrl import fcp_pkg::*; #(
  parameter int NPORTS = FCP_NPORTS
) (
  input logic clk,
  input logic rst,
  input logic ce,
  input logic [15:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [31:0] reg_rdata,
  input logic [3:0] pause_trigger_addr,
  input logic pause_trigger_strobe,
  input fcp_link_rx_t [NPORTS-1:0] link_rx,
  input logic [NPORTS-1:0] link_sync_ok,
  input logic [NPORTS-1:0] fifo_above_high,
  input logic [NPORTS-1:0] fifo_below_low,
  input logic [NPORTS-1:0] mac_tx_busy,
  output logic [NPORTS-1:0] tx_pause_hold,
  output logic [NPORTS-1:0] link_pass,
  output logic [NPORTS-1:0] pf_valid,
  output fcp_pf_t [NPORTS-1:0] pf,
  input logic [NPORTS-1:0] pf_ready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    fcp_port_t [NPORTS-1:0] port;
    logic [3:0] qpre;
    logic qtick;
    logic [4:0] trig1;
    logic [4:0] trig2;
    logic trig_prev;
    logic [31:0] rdata;
  } fcp_state_t;

  fcp_state_t s, next_s;
  logic [NPORTS-1:0] byte_stb;
  logic [NPORTS-1:0] rx_seen;
  logic [NPORTS-1:0][15:0] rx_time;
  logic [NPORTS-1:0] gen_busy;
  logic [NPORTS-1:0] gen_start;
  logic [NPORTS-1:0][15:0] gen_time;
  logic [6:0] reg_port;
  logic [6:0] reg_idx;
  logic trig_fall;
  logic [3:0] trig_addr;

  // word index split into port and register
  assign reg_port = reg_addr[15:9];
  assign reg_idx = reg_addr[8:2];

  // ----------------------------------------------------------------
  // per-port link sampling, parser and frame generator
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    // a rising link clock edge seen after the synchroniser marks a byte
    assign byte_stb[p] = s.port[p].lnk2.clk & ~s.port[p].lclk_prev;
    // autoneg engine is absent, so only forced mode ever passes packets
    assign link_pass[p] = s.port[p].ok2 & ~s.port[p].misc[FCP_AN_ON_BIT];
    // pending hold already stops new frames from starting
    assign tx_pause_hold[p] = (s.port[p].hold_q != 16'h0000) | s.port[p].hold_pend;

    fcp_rx_parse u_rx (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .stb(byte_stb[p]),
      .rx(s.port[p].lnk2),
      .pass(link_pass[p]),
      .sta(s.port[p].sta),
      .pause_seen(rx_seen[p]),
      .pause_time(rx_time[p])
    );

    fcp_tx_gen u_tx (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .start(gen_start[p]),
      .sta(s.port[p].sta),
      .ptime(gen_time[p]),
      .busy(gen_busy[p]),
      .pf_valid(pf_valid[p]),
      .pf(pf[p]),
      .pf_ready(pf_ready[p])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    gen_start = '0;
    gen_time = '0;
    trig_fall = 1'b0;
    trig_addr = s.trig2[3:0];
    if (rst) begin
      next_s = '0;
      for (int p = 0; p < NPORTS; p++) begin
        next_s.port[p].plen = FCP_PAUSE_LEN_RST;
        next_s.port[p].pthr = FCP_PAUSE_THR_RST;
      end
    end else if (ce) begin
      // trigger port: two flops, then falling edge of the strobe
      next_s.trig1 = {pause_trigger_strobe, pause_trigger_addr};
      next_s.trig2 = s.trig1;
      next_s.trig_prev = s.trig2[4];
      trig_fall = s.trig_prev & ~s.trig2[4];

      // shared pause quantum tick for the advertised timers
      next_s.qtick = (s.qpre == FCP_QCYC_LAST);
      next_s.qpre = next_s.qtick ? 4'h0 : s.qpre + 4'h1;

      // read data stands for one cycle only
      next_s.rdata = '0;

      for (int p = 0; p < NPORTS; p++) begin
        // link inputs: two flops each before anything looks at them
        next_s.port[p].lnk1 = link_rx[p];
        next_s.port[p].lnk2 = s.port[p].lnk1;
        next_s.port[p].lclk_prev = s.port[p].lnk2.clk;
        next_s.port[p].ok1 = link_sync_ok[p];
        next_s.port[p].ok2 = s.port[p].ok1;

        // register writes
        if (reg_wr & (reg_port == 7'(p))) begin
          unique case (reg_idx)
            FCP_REG_STA_LO: next_s.port[p].sta[31:0] = reg_wdata;
            FCP_REG_STA_HI: next_s.port[p].sta[47:32] = reg_wdata[15:0];
            FCP_REG_PAUSE_LEN: next_s.port[p].plen = reg_wdata[15:0];
            FCP_REG_PAUSE_THR: next_s.port[p].pthr = reg_wdata[15:0];
            FCP_REG_FC_EN: next_s.port[p].fc_en = reg_wdata[1:0];
            FCP_REG_TX_CFG: next_s.port[p].adv_cfg = reg_wdata[15:0];
            FCP_REG_MISC: next_s.port[p].misc = reg_wdata[7:0];
            default: ;
          endcase
        end

        // register reads, unmapped words read zero
        if (reg_rd & (reg_port == 7'(p))) begin
          unique case (reg_idx)
            FCP_REG_STA_LO: next_s.rdata = s.port[p].sta[31:0];
            FCP_REG_STA_HI: next_s.rdata = {16'h0000, s.port[p].sta[47:32]};
            FCP_REG_PAUSE_LEN: next_s.rdata = {16'h0000, s.port[p].plen};
            FCP_REG_PAUSE_THR: next_s.rdata = {16'h0000, s.port[p].pthr};
            FCP_REG_FC_EN: next_s.rdata = {30'h0, s.port[p].fc_en};
            FCP_REG_RX_CFG: begin
              next_s.rdata[FCP_RXCFG_SYNC_BIT] = s.port[p].ok2;
              next_s.rdata[FCP_RXCFG_AN_DONE_BIT] = 1'b0;
            end
            FCP_REG_TX_CFG: next_s.rdata = {16'h0000, s.port[p].adv_cfg};
            FCP_REG_MISC: next_s.rdata = {24'h000000, s.port[p].misc};
            default: next_s.rdata = '0;
          endcase
        end

        // ------------------------------------------------------------
        // receive side: hold the transmitter for the received quanta
        // ------------------------------------------------------------
        if (s.port[p].hold_q != 16'h0000) begin
          if (s.port[p].hold_pre == FCP_QCYC_LAST) begin
            next_s.port[p].hold_pre = 4'h0;
            next_s.port[p].hold_q = s.port[p].hold_q - 16'h0001;
          end else begin
            next_s.port[p].hold_pre = s.port[p].hold_pre + 4'h1;
          end
        end
        // the latest valid pause wins; filter settings play no part
        if (rx_seen[p] & s.port[p].fc_en[FCP_FC_RX_BIT]) begin
          next_s.port[p].hold_pend = 1'b1;
          next_s.port[p].hold_pend_q = rx_time[p];
        end
        // a frame on the wire is finished before the hold begins
        if (next_s.port[p].hold_pend & ~mac_tx_busy[p]) begin
          next_s.port[p].hold_pend = 1'b0;
          next_s.port[p].hold_q = next_s.port[p].hold_pend_q;
          next_s.port[p].hold_pre = 4'h0;
        end
        if (!s.port[p].fc_en[FCP_FC_RX_BIT]) begin
          next_s.port[p].hold_pend = 1'b0;
          next_s.port[p].hold_q = 16'h0000;
        end

        // ------------------------------------------------------------
        // transmit side: advertised pause runs down in quanta
        // ------------------------------------------------------------
        if (s.qtick & (s.port[p].remain != 16'h0000)) begin
          next_s.port[p].remain = s.port[p].remain - 16'h0001;
        end
        if (next_s.port[p].remain == 16'h0000) begin
          next_s.port[p].xoff_on = 1'b0;
        end

        // launch a frame; xoff beats xon when both wait
        if ((s.port[p].pend_xoff | s.port[p].pend_xon) & ~gen_busy[p] & link_pass[p]) begin
          gen_start[p] = 1'b1;
          gen_time[p] = s.port[p].pend_xoff ? s.port[p].plen : 16'h0000;
          next_s.port[p].pend_xoff = 1'b0;
          next_s.port[p].pend_xon = 1'b0;
          next_s.port[p].remain = gen_time[p];
          next_s.port[p].xoff_on = (gen_time[p] != 16'h0000);
        end

        // watermarks; new events are set after the launch clears them
        if (s.port[p].fc_en[FCP_FC_TX_BIT]) begin
          if (~s.port[p].congest & fifo_above_high[p]) begin
            next_s.port[p].congest = 1'b1;
            next_s.port[p].pend_xoff = 1'b1;
          end else if (s.port[p].congest & fifo_below_low[p]) begin
            next_s.port[p].congest = 1'b0;
            if (s.port[p].xoff_on) begin
              next_s.port[p].pend_xon = 1'b1;
              next_s.port[p].pend_xoff = 1'b0;
            end
          end else if (s.port[p].congest & s.port[p].xoff_on & ~gen_start[p]
                       & ~gen_busy[p] & (s.port[p].remain <= s.port[p].pthr)) begin
            next_s.port[p].pend_xoff = 1'b1;
          end
        end else begin
          next_s.port[p].congest = 1'b0;
          next_s.port[p].pend_xoff = 1'b0;
          next_s.port[p].pend_xon = 1'b0;
        end

        // external trigger, only on ports with transmit pause enabled
        if (trig_fall & s.port[p].fc_en[FCP_FC_TX_BIT]) begin
          if (trig_addr == FCP_TRIG_XON) begin
            next_s.port[p].pend_xon = 1'b1;
            next_s.port[p].pend_xoff = 1'b0;
          end else if ((trig_addr == FCP_TRIG_ALL)
                       | ((trig_addr <= FCP_TRIG_LAST) & (trig_addr == 4'(p + 1)))) begin
            next_s.port[p].pend_xoff = 1'b1;
            next_s.port[p].pend_xon = 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign reg_rdata = s.rdata;

endmodule

// >>> rtl/fcp_pkg.sv
// fcp_pkg: shared constants and carrier types of the pause flow-control block.
// assumes a 25 MHz core clock and word-indexed per-port registers.
package fcp_pkg;

  // ----------------------------------------------------------------
  // sizes and register map
  // ----------------------------------------------------------------
  localparam int FCP_NPORTS = 10;
  localparam logic [6:0] FCP_REG_STA_LO = 7'h00;
  localparam logic [6:0] FCP_REG_STA_HI = 7'h01;
  localparam logic [6:0] FCP_REG_PAUSE_LEN = 7'h07;
  localparam logic [6:0] FCP_REG_PAUSE_THR = 7'h0e;
  localparam logic [6:0] FCP_REG_FC_EN = 7'h12;
  localparam logic [6:0] FCP_REG_RX_CFG = 7'h16;
  localparam logic [6:0] FCP_REG_TX_CFG = 7'h17;
  localparam logic [6:0] FCP_REG_MISC = 7'h18;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int FCP_FC_RX_BIT = 0;
  localparam int FCP_FC_TX_BIT = 1;
  localparam int FCP_AN_ON_BIT = 5;
  localparam int FCP_RXCFG_SYNC_BIT = 20;
  localparam int FCP_RXCFG_AN_DONE_BIT = 21;
  localparam logic [15:0] FCP_PAUSE_LEN_RST = 16'h005e;
  localparam logic [15:0] FCP_PAUSE_THR_RST = 16'h000f;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam logic [47:0] FCP_PAUSE_MCAST = 48'h0180c2000001;
  localparam logic [15:0] FCP_CTRL_TYPE = 16'h8808;
  localparam logic [15:0] FCP_PAUSE_OPCODE = 16'h0001;
  localparam logic [4:0] FCP_HDR_BYTES = 5'h12;
  localparam logic [5:0] FCP_LAST_IDX = 6'h3b;
  localparam logic [7:0] FCP_K28_1 = 8'h3c;

  // ----------------------------------------------------------------
  // trigger decodes
  // ----------------------------------------------------------------
  localparam logic [3:0] FCP_TRIG_XON = 4'h0;
  localparam logic [3:0] FCP_TRIG_LAST = 4'ha;
  localparam logic [3:0] FCP_TRIG_ALL = 4'hf;

  // ----------------------------------------------------------------
  // timing: one pause quantum is 512 bit times at 1 ns per bit
  // ----------------------------------------------------------------
  localparam int FCP_QUANTUM_BITS = 512;
  localparam int FCP_BIT_PS = 1000;
  localparam int FCP_CLK_PS = 40000;
  localparam int FCP_QUANTUM_CYC = (FCP_QUANTUM_BITS * FCP_BIT_PS + FCP_CLK_PS - 1) / FCP_CLK_PS;
  localparam logic [3:0] FCP_QCYC_LAST = 4'(FCP_QUANTUM_CYC - 1);

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic clk;
    logic dv;
    logic k;
    logic [7:0] data;
  } fcp_link_rx_t;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } fcp_pf_t;

  typedef struct packed {
    logic [47:0] sta;
    logic [15:0] plen;
    logic [15:0] pthr;
    logic [1:0] fc_en;
    logic [15:0] adv_cfg;
    logic [7:0] misc;
    fcp_link_rx_t lnk1;
    fcp_link_rx_t lnk2;
    logic lclk_prev;
    logic ok1;
    logic ok2;
    logic congest;
    logic xoff_on;
    logic [15:0] remain;
    logic pend_xoff;
    logic pend_xon;
    logic hold_pend;
    logic [15:0] hold_pend_q;
    logic [15:0] hold_q;
    logic [3:0] hold_pre;
  } fcp_port_t;

  // byte i of a 48-bit address, first byte on the wire in the top bits
  function automatic logic [7:0] fcp_addr_byte(input logic [47:0] a, input logic [5:0] i);
    fcp_addr_byte = a[8'd47 - {i[4:0], 3'b000} -: 8];
  endfunction

endpackage

// >>> rtl/fcp_rx_parse.sv
// fcp_rx_parse: spots pause frames in one port's received byte stream.
// assumes bytes arrive with a one-cycle strobe and dv framing each packet.
`timescale 1ns/1ps
module fcp_rx_parse import fcp_pkg::*; (
  input logic clk,
  input logic rst,
  input logic ce,
  input logic stb,
  input fcp_link_rx_t rx,
  input logic pass,
  input logic [47:0] sta,
  output logic pause_seen,
  output logic [15:0] pause_time
);

  typedef struct packed {
    logic in_frame;
    logic [4:0] idx;
    logic mc_ok;
    logic st_ok;
    logic hdr_ok;
    logic bad;
    logic [15:0] ptime;
    logic seen;
  } fcp_rx_state_t;

  fcp_rx_state_t s, next_s;

  // ----------------------------------------------------------------
  // header walk; frame filters are deliberately not consulted here
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.seen = 1'b0;
    if (rst) begin
      next_s = '0;
    end else if (ce & stb) begin
      if (rx.dv & pass) begin
        if (!s.in_frame) begin
          next_s.in_frame = 1'b1;
          next_s.idx = 5'h00;
          next_s.mc_ok = 1'b1;
          next_s.st_ok = 1'b1;
          next_s.hdr_ok = 1'b1;
          next_s.bad = 1'b0;
        end
        // control words inside a frame spoil it, unknown ones included
        if (rx.k | (rx.k & rx.data == FCP_K28_1)) begin
          next_s.bad = 1'b1;
        end
        if (next_s.idx < 5'h06) begin
          if (rx.data != fcp_addr_byte(FCP_PAUSE_MCAST, {1'b0, next_s.idx})) begin
            next_s.mc_ok = 1'b0;
          end
          if (rx.data != fcp_addr_byte(sta, {1'b0, next_s.idx})) begin
            next_s.st_ok = 1'b0;
          end
        end
        unique case (next_s.idx)
          5'h0c: next_s.hdr_ok = next_s.hdr_ok & (rx.data == FCP_CTRL_TYPE[15:8]);
          5'h0d: next_s.hdr_ok = next_s.hdr_ok & (rx.data == FCP_CTRL_TYPE[7:0]);
          5'h0e: next_s.hdr_ok = next_s.hdr_ok & (rx.data == FCP_PAUSE_OPCODE[15:8]);
          5'h0f: next_s.hdr_ok = next_s.hdr_ok & (rx.data == FCP_PAUSE_OPCODE[7:0]);
          5'h10: next_s.ptime[15:8] = rx.data;
          5'h11: next_s.ptime[7:0] = rx.data;
          default: ;
        endcase
        if (next_s.idx != FCP_HDR_BYTES) begin
          next_s.idx = next_s.idx + 5'h01;
        end
      end else if (s.in_frame) begin
        // frame closes on the first strobe without dv (idle gap)
        next_s.in_frame = 1'b0;
        next_s.seen = pass & (s.idx == FCP_HDR_BYTES) & s.hdr_ok & ~s.bad
                      & (s.mc_ok | s.st_ok);
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign pause_seen = s.seen;
  assign pause_time = s.ptime;

endmodule

// >>> rtl/fcp_tx_gen.sv
// fcp_tx_gen: streams one 60-byte pause frame; the mac appends the fcs.
// assumes the consumer takes a byte when valid and ready are both high.
`timescale 1ns/1ps
module fcp_tx_gen import fcp_pkg::*; (
  input logic clk,
  input logic rst,
  input logic ce,
  input logic start,
  input logic [47:0] sta,
  input logic [15:0] ptime,
  output logic busy,
  output logic pf_valid,
  output fcp_pf_t pf,
  input logic pf_ready
);

  typedef struct packed {
    logic busy;
    logic [5:0] idx;
    logic [47:0] sa;
    logic [15:0] t;
    fcp_pf_t out;
  } fcp_tx_state_t;

  fcp_tx_state_t s, next_s;

  // frame byte i: da, sa, type, opcode, time, then zero pad
  function automatic logic [7:0] frame_byte(input logic [5:0] i, input logic [47:0] sa,
                                            input logic [15:0] t);
    if (i < 6'h06) frame_byte = fcp_addr_byte(FCP_PAUSE_MCAST, i);
    else if (i < 6'h0c) frame_byte = fcp_addr_byte(sa, i - 6'h06);
    else if (i == 6'h0c) frame_byte = FCP_CTRL_TYPE[15:8];
    else if (i == 6'h0d) frame_byte = FCP_CTRL_TYPE[7:0];
    else if (i == 6'h0e) frame_byte = FCP_PAUSE_OPCODE[15:8];
    else if (i == 6'h0f) frame_byte = FCP_PAUSE_OPCODE[7:0];
    else if (i == 6'h10) frame_byte = t[15:8];
    else if (i == 6'h11) frame_byte = t[7:0];
    else frame_byte = 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // byte sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (rst) begin
      next_s = '0;
    end else if (ce) begin
      if (start & ~s.busy) begin
        next_s.busy = 1'b1;
        next_s.idx = 6'h00;
        next_s.sa = sta;
        next_s.t = ptime;
        next_s.out.data = frame_byte(6'h00, sta, ptime);
        next_s.out.last = 1'b0;
      end else if (s.busy & pf_ready) begin
        if (s.out.last) begin
          next_s.busy = 1'b0;
        end else begin
          next_s.idx = s.idx + 6'h01;
          next_s.out.data = frame_byte(next_s.idx, s.sa, s.t);
          next_s.out.last = (next_s.idx == FCP_LAST_IDX);
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign busy = s.busy;
  assign pf_valid = s.busy;
  assign pf = s.out;

endmodule

// >>> verification/fcp_flow_ctrl_chk.sv
// fcp_flow_ctrl_chk: port-level checks of the pause block, port 0 traffic.
// assumes one clock domain with a synchronous reset.
`timescale 1ns/1ps
module fcp_flow_ctrl_chk import fcp_pkg::*; #(
  parameter int NPORTS = FCP_NPORTS
) (
  input logic clk,
  input logic rst,
  input logic [15:0] reg_addr,
  input logic reg_rd,
  input logic [31:0] reg_rdata,
  input logic [NPORTS-1:0] link_sync_ok,
  input logic [NPORTS-1:0] link_pass,
  input logic [NPORTS-1:0] pf_valid,
  input fcp_pf_t [NPORTS-1:0] pf,
  input logic [NPORTS-1:0] pf_ready
);
  logic [5:0] nb;
  wire v0 = pf_valid[0];
  wire tk = pf_valid[0] & pf_ready[0];
  // ----
  // bytes taken in the current frame
  // ----
  always_ff @(posedge clk) begin
    if (rst || (tk && pf[0].last)) begin
      nb <= 6'h00;
    end else if (tk) begin
      nb <= nb + 6'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // outputs tied to their causes
  chk_rdata_zero: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data not cleared");
  chk_bad_port: assert property (reg_rd && reg_addr[15:9] >= 7'(NPORTS) |=> reg_rdata == '0)
    else $error("absent port read nonzero");
  chk_rst_quiet: assert property ($fell(rst) |-> pf_valid == '0 && link_pass == '0)
    else $error("outputs busy after reset");
  chk_byte_stands: assert property (v0 && !pf_ready[0] |=> v0 && $stable(pf[0]))
    else $error("frame byte dropped");
  chk_gap_after: assert property (tk && pf[0].last |=> !v0)
    else $error("no gap after frame");
  chk_frame_len: assert property (v0 && pf[0].last |-> nb == 6'h3b)
    else $error("frame length wrong");
  chk_first_da: assert property ($rose(v0) |-> pf[0].data == 8'h01)
    else $error("first byte wrong");
  chk_sync_gate: assert property (!link_sync_ok[0] [*3] |=> !link_pass[0])
    else $error("link passes unsynced");
endmodule

bind fcp_flow_ctrl fcp_flow_ctrl_chk #(.NPORTS(NPORTS)) fcp_flow_ctrl_chk_inst (.*);

// >>> verification/fcp_link_partner.sv
// fcp_link_partner: far-end mac sending frames into one port's rx path.
// assumes calls start just after a core clock edge, one frame at a time.
`timescale 1ns/1ps
module fcp_link_partner import fcp_pkg::*; (
  input logic quiet,
  output fcp_link_rx_t rx
);
  // link clock stands low outside frames
  initial rx = '0;
  // 64 bytes then three idle periods; bytes change at the falling edge
  task automatic send(input logic [47:0] da, input logic [31:0] tyop, input logic [15:0] t);
    logic [143:0] h;
    h = {da, 48'h020000000077, tyop, t};
    // no new frame starts while a pause towards this partner is in flight
    for (int q = 0; q < 2000 && quiet; q++) #40;
    #7;
    for (int i = 0; i < 67; i++) begin
      rx.dv = i < 64;
      rx.k = 1'b0;
      rx.data = i < 18 ? h[143 - 8 * i -: 8] : (i < 64 ? 8'h00 : ~rx.data);
      #160 rx.clk = 1'b1;
      #160 rx.clk = 1'b0;
    end
    rx.data = ~rx.data;
  endtask
endmodule

// >>> verification/tb.sv
// tb: self-checking bench of the pause block, port 0 in focus.
// assumes the link partner feeds port 0 and other ports stay idle.
`timescale 1ns/1ps
module tb;
  import fcp_pkg::*;
  logic clk, rst, wr_s, rd_s, strb;
  logic [15:0] addr;
  logic [31:0] wd, rdat, d;
  logic [3:0] ta;
  logic [9:0] sync, hi, lo, rdy, pv, hold, lp;
  fcp_pf_t [9:0] pfo;
  fcp_link_rx_t prx;
  int fails, n_compared, cnt;
  logic [82:0] rx_rows [5] = '{{48'h0180c2000001, 32'h88080001, 3'h7},
    {48'h020000000042, 32'h88080001, 3'h7}, {48'h0180c2000001, 32'h88080002, 3'h6},
    {48'h0180c2000001, 32'h88090001, 3'h6}, {48'h0180c2000001, 32'h88080001, 3'h4}};
  logic [6:0] tg_rows [6] = '{7'h71, 7'h60, 7'h7f, 7'h4b, 7'h42, 7'h01};
  fcp_flow_ctrl fcp_flow_ctrl_inst (.clk(clk), .rst(rst), .ce(1'b1), .reg_addr(addr),
    .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .pause_trigger_addr(ta),
    .pause_trigger_strobe(strb), .link_rx({99'h0, prx}), .link_sync_ok(sync),
    .fifo_above_high(hi), .fifo_below_low(lo), .mac_tx_busy(10'h0), .tx_pause_hold(hold),
    .link_pass(lp), .pf_valid(pv), .pf(pfo), .pf_ready(rdy));
  fcp_link_partner fcp_link_partner_inst (.quiet(pv[0]), .rx(prx));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [15:0] ra(input logic [6:0] p, input logic [6:0] r);
    return {p, r, 2'b00};
  endfunction
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    addr <= a;
    wd <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    v = rdat;
  endtask
  task automatic trig(input logic [3:0] a);
    ta <= a;
    repeat (2) @(posedge clk);
    strb <= 1'b1;
    repeat (3) @(posedge clk);
    strb <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // takes one pause frame from port 0, stalling every other cycle
  task automatic frame(input logic [15:0] t);
    logic [143:0] h;
    int i, w;
    h = {48'h0180c2000001, 48'h020000000042, 32'h88080001, t};
    i = 0;
    w = 0;
    while (i < 60 && w < 1200) begin
      @(posedge clk);
      w++;
      if (pv[0] && rdy[0]) begin
        chk(pfo[0], {i == 59, i < 18 ? h[143 - 8 * i -: 8] : 8'h00});
        i++;
      end
      rdy[0] <= ~rdy[0];
    end
    if (w >= 1200) begin
      fails++;
      close_out();
    end
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    {wr_s, rd_s, strb, ta, addr, wd, sync, hi, lo} = '0;
    rdy = 10'h3ff;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ra(9, 7'h07), d);
    chk(d, 32'h5e);
    rd(ra(0, 7'h18), d);
    chk(d, 32'h0);
    wr(ra(0, 7'h16), 32'hffffffff);
    rd(ra(0, 7'h16), d);
    chk(d, 32'h0);
    wr(ra(0, 7'h00), 32'h42);
    wr(ra(0, 7'h01), 32'h0200);
    sync[0] <= 1'b1;
    repeat (4) @(posedge clk);
    chk(lp[0], 1);
    // received pause frames: accepted ones hold the transmitter two quanta
    foreach (rx_rows[j]) begin
      wr(ra(0, 7'h12), {30'h0, rx_rows[j][2:1]});
      fork
        fcp_link_partner_inst.send(rx_rows[j][82:35], rx_rows[j][34:3], 16'h0002);
      join_none
      cnt = 0;
      repeat (700) begin
        @(posedge clk);
        cnt += hold[0];
      end
      chk(cnt inside {[26:28]} ? 1 : (cnt != 0 ? 2 : 0), rx_rows[j][0]);
    end
    wr(ra(0, 7'h07), 32'h14);
    rd(ra(0, 7'h07), d);
    chk(d, 32'h14);
    wr(ra(0, 7'h0e), 32'h2);
    hi[0] <= 1'b1;
    frame(16'h0014);
    frame(16'h0014);
    hi[0] <= 1'b0;
    lo[0] <= 1'b1;
    frame(16'h0000);
    lo[0] <= 1'b0;
    // external trigger decodes, with and without the transmit enable
    foreach (tg_rows[j]) begin
      wr(ra(0, 7'h12), {30'h0, tg_rows[j][6], 1'b1});
      trig(tg_rows[j][3:0]);
      if (tg_rows[j][5]) begin
        frame(tg_rows[j][4] ? 16'h0014 : 16'h0000);
      end else begin
        cnt = 0;
        repeat (40) begin
          @(posedge clk);
          cnt += pv[0];
        end
        chk(cnt, 0);
      end
    end
    wr(ra(0, 7'h18), 32'h20);
    repeat (3) @(posedge clk);
    chk(lp[0], 0);
    wr(ra(0, 7'h18), 32'h0);
    sync[0] <= 1'b0;
    repeat (5) @(posedge clk);
    chk(lp[0], 0);
    close_out();
  end
endmodule
